// ==== srap_host.sv ====
// host spi master model driving the serial register access port
`timescale 1ns/1ps
module srap_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  // half period of the 48 ns serial clock
  localparam int HALF = 24;
  logic three_wire;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
    din = 1'b0;
    three_wire = 1'b0;
    // select starts low so that the reset pulse gives the port clear a real rising edge
    #10;
    cs_n = 1'b1;
  end
  // ****************************************
  // bit level
  // ****************************************
  // drive on the falling edge, capture on the rising edge
  task automatic bit_io(input logic b, input logic oe_exp, output logic q, output logic bad);
    sclk = 1'b0;
    din = b;
    #HALF;
    sclk = 1'b1;
    q = dout;
    bad = (dout_oe !== oe_exp);
    #HALF;
  endtask
  // ****************************************
  // frames
  // ****************************************
  // command byte first, then n data bits; clock stands still between frames
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                       output logic [31:0] rv, output logic bad);
    logic q;
    logic b1;
    logic rd;
    rd = cmd[6] & ~cmd[7];
    rv = 32'h0;
    bad = 1'b0;
    cs_n = 1'b0;
    #HALF;
    for (int i = 7; i >= 0; i--) begin
      bit_io(cmd[i], 1'b0, q, b1);
      bad |= b1;
    end
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(wd[i], rd, q, b1);
      bad |= b1;
      rv = {rv[30:0], q};
    end
    cs_n = ~three_wire;
    // the data line must not keep showing a stale bit
    din = ~din;
    #HALF;
    if (!three_wire) begin
      bad |= (dout_oe !== 1'b0);
    end
  endtask
  // device reset by a run of ones, after power-up or lost framing
  task automatic ones(input int n);
    logic q;
    logic b1;
    cs_n = 1'b0;
    #HALF;
    repeat (n) bit_io(1'b1, 1'b0, q, b1);
    cs_n = ~three_wire;
    din = 1'b0;
    #HALF;
  endtask
endmodule

// ==== srap_hs_if.sv ====
// word handshake carrier between the system clock side and the serial clock side
`timescale 1ns/1ps
interface srap_hs_if;
  logic [srap_pkg::STAT_W-1:0] src_word;
  logic src_load;
  logic src_ready;
  logic [srap_pkg::STAT_W-1:0] dst_word;
  modport user(output src_word, output src_load, input src_ready, input dst_word);
  modport xing(input src_word, input src_load, output src_ready, output dst_word);
endinterface

// ==== srap_hsx.sv ====
// toggle handshake that carries a status word from clk into the serial clock domain
`timescale 1ns/1ps
module srap_hsx (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  srap_hs_if.xing x
);
  import srap_pkg::*;
  // ****************************************
  // source side
  // ****************************************
  srap_stat_t hold, next_hold;
  logic req, next_req;
  logic ack_m, ack_s;
  logic ack, next_ack;
  always_comb begin
    next_hold = hold;
    next_req = req;
    if (x.src_load && (ack_s == req)) begin
      next_hold = x.src_word;
      next_req = ~req;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold <= '0;
      req <= 1'b0;
      ack_m <= 1'b0;
      ack_s <= 1'b0;
      x.src_ready <= 1'b0;
    end else begin
      hold <= next_hold;
      req <= next_req;
      ack_m <= ack;
      ack_s <= ack_m;
      x.src_ready <= (ack_s == next_req);
    end
  end
  // ****************************************
  // serial side
  // ****************************************
  // only advances while the serial clock runs, so the word may be a frame old
  logic req_m, req_s;
  srap_stat_t next_word;
  always_comb begin
    next_ack = ack;
    next_word = x.dst_word;
    if (req_s != ack) begin
      next_word = hold;
      next_ack = req_s;
    end
  end
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      ack <= 1'b0;
      x.dst_word <= '0;
    end else begin
      req_m <= req;
      req_s <= req_m;
      ack <= next_ack;
      x.dst_word <= next_word;
    end
  end
endmodule

// ==== srap_pkg.sv ====
// constants, types and helpers shared by the serial register access port
package srap_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  localparam logic [5:0] ADDR_ID = 6'h07;
  localparam logic [5:0] ADDR_OFFSET = 6'h30;
  localparam logic [1:0] CH_GROUP = 2'h1;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [15:0] CH0_RESET = 16'h8001;
  localparam logic [15:0] CHN_RESET = 16'h0001;
  localparam logic [23:0] OFFSET_RESET = 24'h800000;
  // identification value is arbitrary
  localparam logic [15:0] ID_CODE = 16'h5A50;
  localparam int CH_EN_BIT = 15;
  localparam int NUM_CH = 16;
  // ****************************************
  // command byte fields
  // ****************************************
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_RW_BIT = 6;
  localparam logic [4:0] CMD_LAST = 5'h07;
  // ****************************************
  // timing
  // ****************************************
  localparam logic [6:0] ONES_LAST = 7'h3F;
  localparam logic [6:0] ONES_SAT = 7'h40;
  localparam int CLK_MHZ = 200;
  localparam int SEQ_STEP_NS = 1000;
  localparam int SEQ_STEP_CYC = (SEQ_STEP_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] SEQ_LAST = 8'(SEQ_STEP_CYC - 1);
  localparam int STAT_W = 28;
  typedef logic [STAT_W-1:0] srap_stat_t;
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b100
  } srap_state_e;
  // data phase length in bits for a register address
  function automatic logic [5:0] srap_len(input logic [5:0] a);
    if (a == ADDR_DATA) begin
      return 6'h20;
    end else if (a == ADDR_ID) begin
      return 6'h10;
    end else if (a[5:4] == CH_GROUP) begin
      return 6'h10;
    end else if (a == ADDR_OFFSET) begin
      return 6'h18;
    end else begin
      return 6'h08;
    end
  endfunction
endpackage

// ==== srap_top.sv ====
// serial register access port with register file and channel sequencer
`timescale 1ns/1ps
//
// Functional notes
// RULE1 - drive on falling, sample on rising edge
// RULE2 - mode 3, also with select tied low
// RULE3 - command register is 8 bits, write only
// RULE4 - after any reset wait for command
// RULE5 - command picks direction and register address
// RULE6 - after data phase wait for command
// RULE7 - 64 ones on data in reset all
// RULE8 - select high aborts, keeps registers
// RULE9 - host writes 8, 16 or 24 bits
// RULE10 - reads shift out 8 to 32 bits
// RULE11 - command resets zero; gate, direction, address
// RULE12 - fixed read-only identification register
// RULE13 - host resets device after power up
// RULE14 - host resets device when framing lost
// RULE15 - sequencer steps enabled channels ascending
// RULE16 - command with gate bit set ignored
module srap_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic [3:0] active_channel,
  output logic seq_step
);
  import srap_pkg::*;
  // ****************************************
  // serial port state
  // ****************************************
  // select high clears the port without a clock edge; registers use rst only
  logic port_clr;
  assign port_clr = rst | cs_n; // [RULE8] [RULE2]
  srap_state_e state, next_state;
  logic [4:0] bitcnt, next_bitcnt;
  logic [31:0] shreg, next_shreg;
  logic [6:0] ones_cnt, next_ones_cnt;
  logic [31:0] rd_shift, next_rd_shift;
  logic [7:0] command_register, next_command_register;
  logic [15:0] chan [NUM_CH];
  logic [15:0] next_chan [NUM_CH];
  logic [23:0] offset_reg, next_offset_reg;
  logic reset_tgl, next_reset_tgl;
  logic [7:0] cmd_byte;
  logic [31:0] data_word;
  logic [5:0] data_len;
  logic [5:0] rd_len;
  logic [31:0] rd_value;
  logic full_reset;
  logic cmd_done;
  logic phase_done;
  srap_hs_if hs();
  logic [23:0] stat_cnt;
  logic [3:0] stat_ch;
  assign cmd_byte = {shreg[6:0], din};
  assign data_word = {shreg[30:0], din};
  assign data_len = srap_len(command_register[5:0]);
  assign rd_len = srap_len(cmd_byte[5:0]);
  assign full_reset = (ones_cnt == ONES_LAST) && din; // [RULE7]
  assign cmd_done = (state == ST_CMD) && (bitcnt == CMD_LAST);
  assign phase_done = (bitcnt == 5'(data_len - 6'h01));
  assign stat_cnt = hs.dst_word[27:4];
  assign stat_ch = hs.dst_word[3:0];
  // register read value, selected by the incoming address
  always_comb begin
    if (cmd_byte[5:0] == ADDR_STATUS) begin
      rd_value = {28'h0000000, stat_ch};
    end else if (cmd_byte[5:0] == ADDR_DATA) begin
      rd_value = {stat_cnt, 4'h0, stat_ch};
    end else if (cmd_byte[5:0] == ADDR_ID) begin
      rd_value = {16'h0000, ID_CODE}; // [RULE12]
    end else if (cmd_byte[5:4] == CH_GROUP) begin
      rd_value = {16'h0000, chan[cmd_byte[3:0]]};
    end else if (cmd_byte[5:0] == ADDR_OFFSET) begin
      rd_value = {8'h00, offset_reg};
    end else begin
      rd_value = 32'h00000000;
    end
  end
  always_comb begin
    next_state = state;
    next_bitcnt = 5'(bitcnt + 5'h01);
    next_shreg = data_word; // [RULE1]
    next_ones_cnt = din ? ((ones_cnt == ONES_SAT) ? ones_cnt : 7'(ones_cnt + 7'h01)) : 7'h00;
    next_rd_shift = rd_shift;
    if (full_reset) begin
      next_state = ST_CMD; // [RULE7] [RULE4]
      next_bitcnt = 5'h00;
    end else begin
      case (state)
        ST_CMD: begin
          if (bitcnt == CMD_LAST) begin
            next_bitcnt = 5'h00;
            if (cmd_byte[CMD_WEN_BIT]) begin
              next_state = ST_CMD; // [RULE16]
            end else if (cmd_byte[CMD_RW_BIT]) begin
              next_state = ST_RD; // [RULE5] [RULE11]
              next_rd_shift = rd_value << (6'h20 - rd_len); // [RULE10]
            end else begin
              next_state = ST_WR; // [RULE5]
            end
          end
        end
        ST_WR, ST_RD: begin
          if (phase_done) begin
            next_state = ST_CMD; // [RULE6]
            next_bitcnt = 5'h00;
          end
        end
        default: begin
          next_state = ST_CMD;
          next_bitcnt = 5'h00;
        end
      endcase
    end
  end
  always_ff @(posedge sclk or posedge port_clr) begin
    if (port_clr) begin
      state <= ST_CMD; // [RULE4] [RULE8]
      bitcnt <= 5'h00;
      shreg <= 32'h00000000;
      ones_cnt <= 7'h00;
      rd_shift <= 32'h00000000;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ones_cnt <= next_ones_cnt;
      rd_shift <= next_rd_shift;
    end
  end
  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    next_command_register = command_register;
    next_chan = chan;
    next_offset_reg = offset_reg;
    next_reset_tgl = reset_tgl;
    if (full_reset) begin
      next_command_register = CMD_RESET; // [RULE7] [RULE11]
      for (int i = 0; i < NUM_CH; i++) begin
        next_chan[i] = (i == 0) ? CH0_RESET : CHN_RESET;
      end
      next_offset_reg = OFFSET_RESET;
      next_reset_tgl = ~reset_tgl;
    end else begin
      if (cmd_done && !cmd_byte[CMD_WEN_BIT]) begin
        next_command_register = cmd_byte; // [RULE3] [RULE16]
      end
      if ((state == ST_WR) && phase_done) begin
        if (command_register[5:4] == CH_GROUP) begin
          next_chan[command_register[3:0]] = data_word[15:0];
        end else if (command_register[5:0] == ADDR_OFFSET) begin
          next_offset_reg = data_word[23:0];
        end
      end
    end
  end
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      command_register <= CMD_RESET; // [RULE11]
      for (int i = 0; i < NUM_CH; i++) begin
        chan[i] <= (i == 0) ? CH0_RESET : CHN_RESET;
      end
      offset_reg <= OFFSET_RESET;
      reset_tgl <= 1'b0;
    end else begin
      command_register <= next_command_register;
      chan <= next_chan;
      offset_reg <= next_offset_reg;
      reset_tgl <= next_reset_tgl;
    end
  end
  // ****************************************
  // data out, driven on falling edges
  // ****************************************
  logic next_dout, next_dout_oe;
  always_comb begin
    next_dout_oe = (state == ST_RD);
    next_dout = dout;
    if (state == ST_RD) begin
      next_dout = rd_shift[5'(5'h1F - bitcnt)]; // [RULE1] [RULE10]
    end
  end
  always_ff @(negedge sclk or posedge port_clr) begin
    if (port_clr) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout <= next_dout;
      dout_oe <= next_dout_oe;
    end
  end
  // ****************************************
  // crossings into clk
  // ****************************************
  // enables are quasi-static, each bit stands on its own
  logic [15:0] en_raw, en_m, en_s;
  logic rt_m, rt_s, rt_d;
  logic seq_clear;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      en_raw[i] = chan[i][CH_EN_BIT];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_m <= 16'h0000;
      en_s <= 16'h0000;
      rt_m <= 1'b0;
      rt_s <= 1'b0;
      rt_d <= 1'b0;
    end else begin
      en_m <= en_raw;
      en_s <= en_m;
      rt_m <= reset_tgl;
      rt_s <= rt_m;
      rt_d <= rt_s;
    end
  end
  assign seq_clear = rt_s ^ rt_d;
  // ****************************************
  // channel sequencer
  // ****************************************
  function automatic logic [3:0] pick_next(input logic [15:0] en, input logic [3:0] cur);
    logic [3:0] idx;
    logic [3:0] res;
    res = cur;
    for (int i = NUM_CH; i >= 1; i--) begin
      idx = 4'(cur + 4'(i));
      if (en[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction
  logic [7:0] step_cnt, next_step_cnt;
  logic [23:0] seq_count, next_seq_count;
  logic [3:0] next_active_channel;
  logic next_seq_step;
  always_comb begin
    next_step_cnt = 8'(step_cnt + 8'h01);
    next_seq_count = seq_count;
    next_active_channel = active_channel;
    next_seq_step = 1'b0;
    if (seq_clear) begin
      next_step_cnt = 8'h00;
      next_seq_count = 24'h000000;
      next_active_channel = 4'h0;
    end else if (step_cnt == SEQ_LAST) begin
      next_step_cnt = 8'h00;
      if (|en_s) begin
        next_active_channel = pick_next(en_s, active_channel); // [RULE15]
        next_seq_step = 1'b1;
        next_seq_count = 24'(seq_count + 24'h000001);
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_cnt <= 8'h00;
      seq_count <= 24'h000000;
      active_channel <= 4'h0;
      seq_step <= 1'b0;
    end else begin
      step_cnt <= next_step_cnt;
      seq_count <= next_seq_count;
      active_channel <= next_active_channel;
      seq_step <= next_seq_step;
    end
  end
  assign hs.src_word = {seq_count, active_channel};
  assign hs.src_load = hs.src_ready;
  srap_hsx u_hsx (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .x(hs.xing)
  );
  // ****************************************
  // assertions
  // ****************************************
  logic [5:0] ph_cnt;
  logic higher_en;
  // marks the first edge after a port clear, when a cut phase must not count as finished
  logic after_clr;
  always_ff @(posedge sclk or posedge port_clr) begin
    if (port_clr) begin
      ph_cnt <= 6'h00;
      after_clr <= 1'b1;
    end else begin
      ph_cnt <= (state == ST_CMD) ? 6'h00 : 6'(ph_cnt + 6'h01);
      after_clr <= 1'b0;
    end
  end
  assign higher_en = |(en_s >> (5'(active_channel) + 5'h01));
  sequence s_rd_enter8;
    $rose(state == ST_RD) && (data_len == 6'h08);
  endsequence
  a_wen_gate_ignore: assert property (@(posedge sclk) disable iff (port_clr) // [RULE16]
    cmd_done && cmd_byte[CMD_WEN_BIT] && !full_reset |=>
    (state == ST_CMD) && (bitcnt == 5'h00) && (command_register == $past(command_register)))
    else $error("gated command was taken");
  a_cmd_to_read: assert property (@(posedge sclk) disable iff (port_clr) // [RULE5]
    cmd_done && !cmd_byte[CMD_WEN_BIT] && cmd_byte[CMD_RW_BIT] && !full_reset |=>
    (state == ST_RD) && (command_register == $past(cmd_byte)))
    else $error("read command not started");
  a_read_len_eight: assert property (@(posedge sclk) disable iff (port_clr) // [RULE10]
    s_rd_enter8 and (ones_cnt < 7'h38) |-> (state == ST_RD)[*8] ##1 (state == ST_CMD))
    else $error("8-bit read has wrong length");
  a_phase_end_len: assert property (@(posedge sclk) disable iff (port_clr) // [RULE6]
    (state == ST_CMD) && ($past(state) != ST_CMD) && !$past(full_reset) && !after_clr |->
    $past(ph_cnt) == 6'($past(data_len) - 6'h01))
    else $error("data phase ended at wrong bit");
  a_ones_full_reset: assert property (@(posedge sclk) disable iff (port_clr) // [RULE7]
    full_reset |=> (state == ST_CMD) && (command_register == CMD_RESET) &&
    (offset_reg == OFFSET_RESET) && (chan[0] == CH0_RESET))
    else $error("64 ones did not reset the device");
  a_cmd_field_use: assert property (@(posedge sclk) disable iff (port_clr) // [RULE11]
    (state != ST_CMD) |-> !command_register[CMD_WEN_BIT] &&
    (command_register[CMD_RW_BIT] == (state == ST_RD)))
    else $error("data phase disagrees with command fields");
  a_id_read_value: assert property (@(posedge sclk) disable iff (port_clr) // [RULE12]
    cmd_done && (cmd_byte == {2'h1, ADDR_ID}) && !full_reset |=> rd_shift[31:16] == ID_CODE)
    else $error("identification read wrong");
  a_drive_on_fall: assert property (@(posedge sclk) disable iff (port_clr) // [RULE1]
    (state == ST_RD) |-> dout_oe && (dout == rd_shift[5'(5'h1F - bitcnt)]))
    else $error("read bit not driven on falling edge");
  a_seq_ascending: assert property (@(posedge clk) disable iff (rst) // [RULE15]
    seq_step && $past(higher_en) && !$past(seq_clear) |->
    (active_channel > $past(active_channel)) && en_s[active_channel])
    else $error("sequencer did not step upward");
endmodule

// ==== srap_top_tb.sv ====
// self-checking testbench of the serial register access port
`timescale 1ns/1ps
module srap_top_tb;
  import srap_pkg::*;
  logic clk;
  logic rst;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic seq_step;
  logic [3:0] active_channel;
  int num_errors = 0;
  int total_checks = 0;
  srap_top i_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .active_channel(active_channel), .seq_step(seq_step));
  srap_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // reporting
  // ****************************************
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t flag=%h exp=%h", $time, got, exp);
    end
  endtask
  // ****************************************
  // register access
  // ****************************************
  task automatic wr(input logic [5:0] a, input int n, input logic [31:0] v);
    logic [31:0] r;
    logic bad;
    i_host.frame({2'b00, a}, n, v, r, bad);
    cmp_flag(bad, 1'b0);
  endtask
  task automatic rd(input logic [5:0] a, input int n, input logic [31:0] exp);
    logic [31:0] r;
    logic bad;
    i_host.frame({2'b01, a}, n, 32'h0, r, bad);
    cmp32(r, exp);
    cmp_flag(bad, 1'b0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd(ADDR_ID, 16, {16'h0, ID_CODE});
    rd(6'h10, 16, {16'h0, CH0_RESET});
    wr(6'h11, 16, 32'h0000_8002);
    rd(6'h11, 16, 32'h0000_8002);
    wr(ADDR_OFFSET, 24, 32'h00A5_C3E1);
    rd(ADDR_OFFSET, 24, 32'h00A5_C3E1);
    wr(ADDR_ID, 16, 32'h0000_FFFF);
    rd(ADDR_ID, 16, {16'h0, ID_CODE});
    rd(6'h3F, 8, 32'h0);
  endtask
  // select high in mid-frame drops the transfer but keeps registers
  task automatic t_abort;
    logic [31:0] r;
    logic bad;
    i_host.frame(8'h11, 8, 32'h0000_00FF, r, bad);
    rd(6'h11, 16, 32'h0000_8002);
    i_host.frame(8'h47, 4, 32'h0, r, bad);
    rd(ADDR_ID, 16, {16'h0, ID_CODE});
  endtask
  // select tied low; a gated command byte must be skipped
  task automatic t_gate;
    logic [31:0] r;
    logic bad;
    i_host.three_wire = 1'b1;
    i_host.frame(8'hD1, 0, 32'h0, r, bad);
    rd(ADDR_ID, 16, {16'h0, ID_CODE});
    wr(6'h13, 16, 32'h0000_0005);
    rd(6'h13, 16, 32'h0000_0005);
    i_host.three_wire = 1'b0;
  endtask
  // 63 ones is one short of a reset, 64 restores every default
  task automatic t_ones;
    i_host.ones(63);
    rd(6'h11, 16, 32'h0000_8002);
    i_host.ones(64);
    rd(6'h11, 16, {16'h0, CHN_RESET});
    rd(6'h13, 16, {16'h0, CHN_RESET});
    rd(ADDR_OFFSET, 24, {8'h0, OFFSET_RESET});
    rd(6'h10, 16, {16'h0, CH0_RESET});
  endtask
  // channels 0 and 2 enabled: the sequencer must alternate, skipping 1
  task automatic t_seq;
    logic [3:0] prev;
    int n;
    prev = 4'h0;
    wr(6'h12, 16, 32'h0000_8001);
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (seq_step !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      cmp_flag(seq_step, 1'b1);
      @(negedge clk);
      if (k > 0) begin
        cmp32({28'h0, active_channel}, (prev == 4'h0) ? 32'h2 : 32'h0);
      end
      prev = active_channel;
    end
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    // reset rises after time zero so that every asynchronous reset sees its edge
    rst = 1'b0;
    @(posedge clk);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    i_host.ones(64);
    t_regs();
    t_abort();
    t_gate();
    t_ones();
    t_seq();
    finish_test();
  end
  // the run needs about 40 us; this leaves ample margin
  initial begin
    #300000;
    num_errors++;
    finish_test();
  end
endmodule
